// *** hw/applicator_pkg.sv ***
// Shared constants, register map and carrier types of the applicator status block.
package applicator_pkg;
  // ==========================================================================
  // Timing
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned MOVE_TIMEOUT_MS = 2000;
  localparam int unsigned MS_PER_S = 1000;
  // Longest time, so the count rounds down.
  localparam int unsigned MOVE_TIMEOUT_CYCLES = (CLK_HZ / MS_PER_S) * MOVE_TIMEOUT_MS;
  localparam int unsigned TMR_W = 27;

  // ==========================================================================
  // Register map (byte addresses)
  localparam int unsigned ADR_W = 4;
  localparam logic [ADR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [ADR_W-1:0] REG_FAULT = 4'h8;
  localparam int unsigned CTRL_ACK_BIT = 0;
  localparam int unsigned CTRL_ENABLE_BIT = 1;
  localparam logic CTRL_ENABLE_RESET = 1'h1;
  localparam int unsigned STATUS_HALT_BIT = 8;
  localparam int unsigned STATUS_HELD_BIT = 9;

  // ==========================================================================
  // Pin inputs, bit positions after the synchroniser
  localparam int unsigned PIN_W = 6;
  localparam int unsigned PIN_START = 0;
  localparam int unsigned PIN_STOP = 1;
  localparam int unsigned PIN_FIRST = 2;
  localparam int unsigned PIN_AT_START = 3;
  localparam int unsigned PIN_AT_LABEL = 4;
  localparam int unsigned PIN_VACUUM = 5;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    FAULT_NONE = 3'h0,
    FAULT_LOWER_POS = 3'h1,
    FAULT_UPPER_POS = 3'h2,
    FAULT_PLATE_EMPTY = 3'h3,
    FAULT_NOT_DEPOSITED = 3'h4,
    FAULT_HOST_STOP = 3'h5
  } fault_code_t;

  typedef struct packed {
    logic printer_not_ready_flag;
    logic applicator_fault_flag;
    logic pad_at_label_pos_flag;
    logic pad_at_start_flag;
    logic general_error_flag;
    logic no_job_flag;
  } status_flags_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_t;
endpackage

// *** hw/pin_sync.sv ***
// Two-flip-flop synchroniser for a bank of asynchronous pin inputs.
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end

  assign q = sync_r;
endmodule // pin_sync

// *** hw/move_timer.sv ***
// Movement watchdog: counts while running and flags when the limit is reached.
`timescale 1ns/1ps
module move_timer
  import applicator_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = MOVE_TIMEOUT_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic restart,
  output logic expired
);
  localparam logic [TMR_W-1:0] LIMIT = TMR_W'(TIMEOUT_CYCLES - 1);
  logic [TMR_W-1:0] cnt_r;
  logic [TMR_W-1:0] cnt_nxt;

  always_comb begin
    if (restart || !run) begin
      cnt_nxt = '0;
    end else if (cnt_r == LIMIT) begin
      cnt_nxt = cnt_r;
    end else begin
      cnt_nxt = cnt_r + TMR_W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign expired = run && (cnt_r == LIMIT);
endmodule // move_timer

// *** hw/applicator_status.sv ***
// Applicator labelling sequencer with control-system status contacts and a Wishbone slave.
// How it works
// - The no-job contact opens while the printer has no print job and closes once one exists.
// - The general error contact opens while either the printer is not ready or the applicator is faulted.
// - The pad-at-start contact opens while the start-position sensor sees the pad.
// - The pad-at-label contact opens while the labelling-position sensor sees the pad.
// - A fault is raised if the labelling-position sensor stays inactive 2 s after moving down.
// - A fault is raised if the start-position sensor stays inactive 2 s after moving up.
// - A fault is raised if the vacuum sensor sees no label after pickup or loses it moving down.
// - A fault is raised if the vacuum sensor still sees the label when the pad is back up.
// - The kind of applicator fault is held as a code for the printer display.
// - Clearing an applicator fault never requests a reprint; the next label follows.
// - Each status output is active as an open contact and inactive as a closed one.
// - Printer errors show as printer-not-ready and the last label is reprinted once cleared.
// - A stop during labelling aborts, returns the pad to start and ignores further inputs.
//
// Design decisions made here: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
module applicator_status
  import applicator_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = MOVE_TIMEOUT_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input applicator_pkg::wb_req_t wb_req,
  output applicator_pkg::wb_rsp_t wb_rsp,
  input wire logic [applicator_pkg::PIN_W-1:0] pins,
  input wire logic job_available,
  input wire logic printer_error,
  input wire logic print_done,
  output logic print_label,
  output logic reprint_label,
  output logic cylinder_down,
  output logic vacuum_on,
  output applicator_pkg::fault_code_t display_fault,
  output applicator_pkg::status_flags_t contact_closed
);
  import applicator_pkg::*;

  // ==========================================================================
  // Pin synchronisation and movement watchdog
  logic [PIN_W-1:0] pin_q;
  logic tmr_expired;
  logic tmr_run;
  logic tmr_restart;

  pin_sync #(.W(PIN_W)) u_sync (
    .clk(clk),
    .rst(rst),
    .d(pins),
    .q(pin_q)
  );

  move_timer #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_timer (
    .clk(clk),
    .rst(rst),
    .run(tmr_run),
    .restart(tmr_restart),
    .expired(tmr_expired)
  );

  // ==========================================================================
  // Wishbone slave
  logic ack_r;
  logic ack_nxt;
  logic [31:0] rdat_r;
  logic [31:0] rdat_nxt;
  logic enable_r;
  logic enable_nxt;
  logic wr_fire;
  logic fault_ack;
  status_flags_t flags;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PRINT,
    ST_DOWN,
    ST_UP,
    ST_FAULT,
    ST_HALT
  } state_t;

  state_t state_r;
  state_t state_nxt;
  logic fault_r;
  logic fault_nxt;
  fault_code_t code_r;
  fault_code_t code_nxt;
  logic ignore_r;
  logic ignore_nxt;
  logic held_r;
  logic held_nxt;

  // A write takes effect on the edge at which the master sees ack.
  assign wr_fire = ack_r && wb_req.cyc && wb_req.stb && wb_req.we;
  assign fault_ack = wr_fire && (wb_req.adr == REG_CTRL) && wb_req.sel[0]
                     && wb_req.dat[CTRL_ACK_BIT];

  always_comb begin
    ack_nxt = wb_req.cyc && wb_req.stb && !ack_r;
    enable_nxt = enable_r;
    if (wr_fire && (wb_req.adr == REG_CTRL) && wb_req.sel[0]) begin
      enable_nxt = wb_req.dat[CTRL_ENABLE_BIT];
    end
    rdat_nxt = '0;
    case (wb_req.adr)
      REG_CTRL: rdat_nxt[CTRL_ENABLE_BIT] = enable_r;
      REG_STATUS: begin
        rdat_nxt[$bits(status_flags_t)-1:0] = flags;
        rdat_nxt[STATUS_HALT_BIT] = ignore_r;
        rdat_nxt[STATUS_HELD_BIT] = held_r;
      end
      REG_FAULT: rdat_nxt[$bits(fault_code_t)-1:0] = code_r;
      default: rdat_nxt = '0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
      rdat_r <= '0;
      enable_r <= CTRL_ENABLE_RESET;
    end else begin
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
      enable_r <= enable_nxt;
    end
  end

  assign wb_rsp.ack = ack_r;
  assign wb_rsp.dat = rdat_r;

  // ==========================================================================
  // Labelling sequencer and fault detection
  logic start_q;
  logic stop_q;
  logic first_q;
  logic at_start_q;
  logic at_label_q;
  logic vac_q;
  logic start_d_r;
  logic first_d_r;
  logic start_rise;
  logic first_rise;
  logic labelling;

  assign start_q = pin_q[PIN_START];
  assign stop_q = pin_q[PIN_STOP];
  assign first_q = pin_q[PIN_FIRST];
  assign at_start_q = pin_q[PIN_AT_START];
  assign at_label_q = pin_q[PIN_AT_LABEL];
  assign vac_q = pin_q[PIN_VACUUM];
  assign start_rise = start_q && !start_d_r;
  assign first_rise = first_q && !first_d_r;
  assign labelling = (state_r == ST_PRINT) || (state_r == ST_DOWN);
  assign tmr_run = (state_r == ST_DOWN) || (state_r == ST_UP);
  assign tmr_restart = (state_nxt != state_r);

  always_comb begin
    state_nxt = state_r;
    fault_nxt = fault_r;
    code_nxt = code_r;
    ignore_nxt = ignore_r;
    held_nxt = held_r;
    case (state_r)
      ST_IDLE: begin
        if (!ignore_r && enable_r && !fault_r && !printer_error) begin
          if (start_rise) begin
            state_nxt = held_r ? ST_DOWN : ST_PRINT;
            held_nxt = 1'b0;
          end else if (first_rise && !held_r) begin
            state_nxt = ST_PRINT;
            held_nxt = 1'b1;
          end
        end
      end
      ST_PRINT: begin
        if (stop_q) begin
          state_nxt = ST_UP;
          ignore_nxt = 1'b1;
          code_nxt = FAULT_HOST_STOP;
        end else if (print_done && !vac_q) begin
          state_nxt = ST_FAULT;
          fault_nxt = 1'b1;
          code_nxt = FAULT_PLATE_EMPTY;
        end else if (print_done) begin
          state_nxt = held_r ? ST_IDLE : ST_DOWN;
        end
      end
      ST_DOWN: begin
        if (stop_q) begin
          state_nxt = ST_UP;
          ignore_nxt = 1'b1;
          code_nxt = FAULT_HOST_STOP;
        end else if (!vac_q) begin
          state_nxt = ST_FAULT;
          fault_nxt = 1'b1;
          code_nxt = FAULT_PLATE_EMPTY;
        end else if (at_label_q) begin
          state_nxt = ST_UP;
        end else if (tmr_expired) begin
          state_nxt = ST_FAULT;
          fault_nxt = 1'b1;
          code_nxt = FAULT_LOWER_POS;
        end
      end
      ST_UP: begin
        if (at_start_q && vac_q && !ignore_r) begin
          state_nxt = ST_FAULT;
          fault_nxt = 1'b1;
          code_nxt = FAULT_NOT_DEPOSITED;
        end else if (at_start_q) begin
          state_nxt = ignore_r ? ST_HALT : ST_IDLE;
        end else if (tmr_expired) begin
          state_nxt = ST_FAULT;
          fault_nxt = 1'b1;
          code_nxt = FAULT_UPPER_POS;
        end
      end
      ST_FAULT, ST_HALT: begin
        // Acknowledge drops the fault and resumes with a fresh label, no reprint.
        if (fault_ack) begin
          state_nxt = ST_IDLE;
          fault_nxt = 1'b0;
          ignore_nxt = 1'b0;
          held_nxt = 1'b0;
          code_nxt = FAULT_NONE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      fault_r <= 1'b0;
      code_r <= FAULT_NONE;
      ignore_r <= 1'b0;
      held_r <= 1'b0;
      start_d_r <= 1'b0;
      first_d_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      fault_r <= fault_nxt;
      code_r <= code_nxt;
      ignore_r <= ignore_nxt;
      held_r <= held_nxt;
      start_d_r <= start_q;
      first_d_r <= first_q;
    end
  end

  // ==========================================================================
  // Status contacts and printer-side outputs
  logic perr_d_r;
  status_flags_t contact_nxt;

  always_comb begin
    flags.no_job_flag = !job_available;
    flags.general_error_flag = printer_error || fault_r;
    flags.pad_at_start_flag = at_start_q;
    flags.pad_at_label_pos_flag = at_label_q;
    flags.applicator_fault_flag = fault_r;
    flags.printer_not_ready_flag = printer_error;
    contact_nxt = ~flags;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      contact_closed <= '1;
      print_label <= 1'b0;
      reprint_label <= 1'b0;
      cylinder_down <= 1'b0;
      vacuum_on <= 1'b0;
      display_fault <= FAULT_NONE;
      perr_d_r <= 1'b0;
    end else begin
      contact_closed <= contact_nxt;
      print_label <= (state_nxt == ST_PRINT) && (state_r != ST_PRINT);
      reprint_label <= perr_d_r && !printer_error;
      cylinder_down <= (state_nxt == ST_DOWN);
      // A held first label keeps its vacuum while the pad waits at start.
      vacuum_on <= (state_nxt == ST_PRINT) || (state_nxt == ST_DOWN)
                   || ((state_nxt == ST_IDLE) && held_nxt);
      display_fault <= code_nxt;
      perr_d_r <= printer_error;
    end
  end

  // ==========================================================================
  // Checks
  chk_no_job_contact: assert property (@(posedge clk) disable iff (rst)
    !job_available |=> !contact_closed.no_job_flag) else $error("no-job contact not open");
  chk_general_error: assert property (@(posedge clk) disable iff (rst)
    (printer_error || fault_r) |=> !contact_closed.general_error_flag)
    else $error("general error contact not open");
  chk_pad_start: assert property (@(posedge clk) disable iff (rst)
    contact_closed.pad_at_start_flag == !$past(at_start_q)) else $error("start contact wrong");
  chk_pad_label: assert property (@(posedge clk) disable iff (rst)
    $rose(at_label_q) |=> !contact_closed.pad_at_label_pos_flag)
    else $error("label contact not open");
  chk_lower_timeout: assert property (@(posedge clk) disable iff (rst)
    (state_r == ST_DOWN && !stop_q && vac_q && !at_label_q && tmr_expired)
    |=> fault_r && code_r == FAULT_LOWER_POS && display_fault == FAULT_LOWER_POS)
    else $error("lower position timeout missed");
  chk_upper_timeout: assert property (@(posedge clk) disable iff (rst)
    (state_r == ST_UP && !at_start_q && tmr_expired) |=> state_r == ST_FAULT
    && code_r == FAULT_UPPER_POS) else $error("upper position timeout missed");
  chk_plate_empty: assert property (@(posedge clk) disable iff (rst)
    (state_r == ST_PRINT && !stop_q && print_done && !vac_q)
    |=> fault_r ##1 !contact_closed.applicator_fault_flag) else $error("empty plate missed");
  chk_not_deposited: assert property (@(posedge clk) disable iff (rst)
    (state_r == ST_UP && !ignore_r && at_start_q && vac_q)
    |=> code_r == FAULT_NOT_DEPOSITED) else $error("label left on plate missed");
  chk_fault_sticky: assert property (@(posedge clk) disable iff (rst)
    (fault_r && !fault_ack) |=> fault_r) else $error("fault released without ack");
  chk_no_reprint: assert property (@(posedge clk) disable iff (rst)
    (fault_ack && fault_r && !$fell(printer_error)) |=> !reprint_label)
    else $error("reprint after applicator fault");
  chk_reprint_after: assert property (@(posedge clk) disable iff (rst)
    $fell(printer_error) |=> reprint_label ##1 !reprint_label)
    else $error("reprint pulse wrong");
  chk_stop_abort: assert property (@(posedge clk) disable iff (rst)
    (labelling && stop_q) |=> state_r == ST_UP && ignore_r ##1 !cylinder_down)
    else $error("stop did not abort");
  chk_held_vacuum: assert property (@(posedge clk) disable iff (rst)
    (state_r == ST_IDLE && held_r) |=> vacuum_on) else $error("held label lost vacuum");
endmodule // applicator_status

// *** dv/pad_model.sv ***
// Behavioural model of the pad mechanics, vacuum sensor and label feed around the block.
`timescale 1ns/1ps
module pad_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic cylinder_down,
  input wire logic vacuum_on,
  input wire logic print_label,
  input wire logic [3:0] mode,
  output logic at_start,
  output logic at_label,
  output logic vac,
  output logic print_done
);
  // Mode bits: 0 pad never reaches the label position, 1 pad never returns,
  // 2 label is not picked up, 3 label sticks to the plate.
  int cnt;
  int pcnt;
  logic dir_r;
  logic label_on;
  // ==========================================================================
  // Movement takes ten cycles each way; sensors follow the command.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 1000;
      pcnt <= 0;
      dir_r <= 1'b0;
      label_on <= 1'b0;
      at_start <= 1'b1;
      at_label <= 1'b0;
      vac <= 1'b0;
      print_done <= 1'b0;
    end else begin
      dir_r <= cylinder_down;
      if (cylinder_down != dir_r) cnt <= 0;
      else if (cnt < 1000) cnt <= cnt + 1;
      at_label <= cylinder_down && cnt >= 10 && !mode[0];
      at_start <= !cylinder_down && cnt >= 10 && !mode[1];
      print_done <= (pcnt == 1);
      if (pcnt != 0) pcnt <= pcnt - 1;
      if (!vacuum_on && !mode[3]) label_on <= 1'b0;
      if (print_label) begin
        pcnt <= 6;
        label_on <= !mode[2];
      end
      vac <= label_on;
    end
  end
endmodule // pad_model

// *** dv/tb_applicator_status.sv ***
// Self-checking bench for the applicator status block.
`timescale 1ns/1ps
module tb_applicator_status;
  import applicator_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  wb_req_t req = '0;
  wb_rsp_t rsp;
  logic job = 1'b0;
  logic perr = 1'b0;
  // Bit 0 drives the start request pin, bit 1 the first-label request pin.
  logic [1:0] go = 2'b00;
  logic stop_pin = 1'b0;
  logic [3:0] mode = 4'h0;
  logic at_start, at_label, vac, print_done;
  logic print_label, reprint_label, cylinder_down, vacuum_on;
  fault_code_t display_fault;
  status_flags_t cc;
  logic [5:0] pins, p1, p2, p3;
  logic jd, pd, mon = 1'b0;
  logic [31:0] rd;
  int num_errors = 0;
  int checked = 0;
  int prints = 0;
  int cycles = 0;
  fault_code_t codes[4] = '{FAULT_LOWER_POS, FAULT_UPPER_POS, FAULT_PLATE_EMPTY,
                            FAULT_NOT_DEPOSITED};
  assign pins = {vac, at_label, at_start, go[1], stop_pin, go[0]};
  always #12.5 clk = ~clk;

  applicator_status #(.TIMEOUT_CYCLES(50)) dut (.clk(clk), .rst(rst), .wb_req(req),
    .wb_rsp(rsp), .pins(pins), .job_available(job), .printer_error(perr),
    .print_done(print_done), .print_label(print_label), .reprint_label(reprint_label),
    .cylinder_down(cylinder_down), .vacuum_on(vacuum_on), .display_fault(display_fault),
    .contact_closed(cc));
  pad_model model (.clk(clk), .rst(rst), .cylinder_down(cylinder_down),
    .vacuum_on(vacuum_on), .print_label(print_label), .mode(mode), .at_start(at_start),
    .at_label(at_label), .vac(vac), .print_done(print_done));

  // ==========================================================================
  // Checking and closing.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Contacts open when active; pin-fed flags lag the pins by three edges.
  always @(posedge clk) begin
    jd <= job;
    pd <= perr;
    p1 <= pins;
    p2 <= p1;
    p3 <= p2;
    if (print_label === 1'b1 || reprint_label === 1'b1) prints++;
    if (mon) check(cc & 6'h2d, {~pd, 1'b0, ~p3[4], ~p3[3], 1'b0, jd});
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      finish_test();
    end
  end

  // ==========================================================================
  // Bus and stimulus tasks.
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
    do begin
      @(posedge clk);
    end while (rsp.ack !== 1'b1);
    rd = rsp.dat;
    req <= '0;
    @(posedge clk);
  endtask

  task automatic ack_fault();
    wb(1'b1, REG_CTRL, 32'((1 << CTRL_ACK_BIT) | (1 << CTRL_ENABLE_BIT)));
  endtask

  task automatic pulse_start(input logic [1:0] m = 2'b01);
    @(posedge clk);
    go <= m;
    repeat (4) @(posedge clk);
    go <= 2'b00;
  endtask

  function automatic logic sig(input int w);
    case (w)
      0: return cylinder_down;
      1: return display_fault != FAULT_NONE;
      default: return at_start && !cylinder_down;
    endcase
  endfunction

  task automatic wait_sig(input int w, input logic v);
    int n;
    for (n = 0; n < 400 && sig(w) !== v; n++) @(posedge clk);
    check(n < 400, 1);
  endtask

  // Print and reprint pulses counted since base, after 30 more cycles.
  task automatic count_prints(input int base, input int exp);
    repeat (30) @(posedge clk);
    check(prints - base, exp);
  endtask

  // ==========================================================================
  // Main sequence.
  initial begin
    int i;
    int got;
    void'($urandom(32'hadd6));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    mon <= 1'b1;
    wb(1'b0, 4'hc, 32'h0);
    check(rd, 0);
    wb(1'b0, REG_FAULT, 32'h0);
    check(rd, 0);
    for (i = 0; i < 8; i++) begin
      job <= 1'($urandom);
      perr <= 1'b1;
      repeat ($urandom_range(2, 9)) @(posedge clk);
      check(cc.general_error_flag, 0);
      perr <= 1'b0;
      got = 0;
      repeat (6) begin
        @(posedge clk);
        if (reprint_label === 1'b1) got++;
      end
      check(got, 1);
    end
    job <= 1'b1;
    repeat (2) begin
      pulse_start();
      wait_sig(0, 1);
      check(vacuum_on, 1);
      wait_sig(0, 0);
      wait_sig(2, 1);
      repeat (5) @(posedge clk);
      check(display_fault, FAULT_NONE);
    end
    got = prints;
    pulse_start(2'b10);
    count_prints(got, 1);
    check(cylinder_down, 0);
    wb(1'b0, REG_STATUS, 32'h0);
    check(rd, 32'h204);
    got = prints;
    pulse_start();
    wait_sig(0, 1);
    check(vacuum_on, 1);
    wait_sig(0, 0);
    wait_sig(2, 1);
    repeat (5) @(posedge clk);
    check(display_fault, FAULT_NONE);
    check(prints - got, 0);
    wb(1'b1, REG_CTRL, 32'h0);
    got = prints;
    pulse_start();
    count_prints(got, 0);
    wb(1'b1, REG_CTRL, 32'(1 << CTRL_ENABLE_BIT));
    wb(1'b0, REG_CTRL, 32'h0);
    check(rd, 32'(1 << CTRL_ENABLE_BIT));
    for (i = 0; i < 4; i++) begin
      mode <= 4'(1 << i);
      pulse_start();
      wait_sig(1, 1);
      check(display_fault, codes[i]);
      repeat (3) @(posedge clk);
      check({cc.applicator_fault_flag, cc.general_error_flag}, 2'b00);
      mode <= 4'h0;
      repeat (60) @(posedge clk);
      check({display_fault, cc.applicator_fault_flag}, {codes[i], 1'b0});
      got = prints;
      ack_fault();
      repeat (4) @(posedge clk);
      check({display_fault, cc.applicator_fault_flag, cc.general_error_flag}, 5'h03);
      count_prints(got, 0);
    end
    pulse_start();
    wait_sig(0, 1);
    stop_pin <= 1'b1;
    wait_sig(0, 0);
    repeat (4) @(posedge clk);
    stop_pin <= 1'b0;
    wait_sig(2, 1);
    check({display_fault, cc.applicator_fault_flag}, {FAULT_HOST_STOP, 1'b1});
    wb(1'b0, REG_STATUS, 32'h0);
    check(rd[STATUS_HALT_BIT], 1);
    got = prints;
    pulse_start();
    count_prints(got, 0);
    ack_fault();
    wb(1'b0, REG_STATUS, 32'h0);
    check(rd[STATUS_HALT_BIT], 0);
    finish_test();
  end
endmodule // tb_applicator_status
